// ### include/chc_pkg.sv
// Constants shared by the charge current and throttle flag register logic.
// Assumes a single system clock and a synchronous, active high reset.
//
// Functional notes
// R1 - Seven read-only trigger flags sit in throttle status bits 6..0, reset zero.
// R2 - Host sets the charge current with a 16-bit word write to command 14h.
// R3 - Setpoint spans 64 mA to 8.128 A in 64 mA steps.
// R4 - Setpoint is zero after power-on reset.
// R5 - Source-good falling clears setpoint, except when input overvoltage caused it.
// R6 - Presence pin falling, meaning battery removal, clears setpoint.
// R7 - Overcurrent, thermal shutdown, latch-off, system overvoltage leave setpoint intact.
// R8 - Setpoint bits 12..6 weigh 64 mA up to 4096 mA, binary.
// R9 - Written values in setpoint bits 5..0 are ignored.
// R10 - A setpoint write with any of bits 15..13 set is invalid.
// R11 - Word transfers follow write-word and read-word, low byte first.
package chc_pkg;

  // ****************************************************************
  // Command codes and bus address
  // ****************************************************************
  localparam logic [7:0]  CMD_SETPOINT     = 8'h14;
  localparam logic [7:0]  CMD_THROTTLE     = 8'h21;
  // Arbitrary default bus address, overridable on the top module
  localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h09;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int          FLAG_W           = 7;
  localparam int          MA_W             = 13;
  localparam int          SP_LSB           = 6;
  localparam int          SP_MSB           = 12;
  localparam int          INV_LSB          = 13;
  localparam logic [15:0] SETPOINT_RESET   = 16'h0000;
  localparam logic [6:0]  FLAG_RESET       = 7'h00;
  localparam logic [12:0] MAX_MA           = 13'h1fc0;
  localparam logic [2:0]  LAST_BIT         = 3'h7;
  localparam logic [1:0]  IDX_ADDR         = 2'h0;
  localparam logic [1:0]  IDX_CMD          = 2'h1;
  localparam logic [1:0]  IDX_LO           = 2'h2;
  localparam logic [1:0]  IDX_HI           = 2'h3;

  // ****************************************************************
  // Bus engine states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK_SETUP,
    ST_ACK,
    ST_TX,
    ST_MACK,
    ST_MACK_HOLD,
    ST_IGNORE
  } chc_state_e;

endpackage : chc_pkg

// ### include/chc_line_if.sv
// Decoded bus line events passed from the line monitor to the bus engine.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
`default_nettype none
interface chc_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  modport mon (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport ctl (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : chc_line_if
`default_nettype wire

// ### hdl/chc_line_mon.sv
// Clock and data line monitor: edges, start and stop conditions.
// Assumes line inputs are already synchronous to the system clock.
`timescale 1ns/10ps
`default_nettype none
module chc_line_mon (
  // Clock and reset
  input  wire logic   clk_sys_i,
  input  wire logic   srst_i,
  // Bus lines
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  // Decoded events
  chc_line_if.mon     line
);

  logic scl_q, next_scl_q;
  logic sda_q, next_sda_q;
  logic rise, next_rise;
  logic fall, next_fall;
  logic strt, next_strt;
  logic stp,  next_stp;

  always_comb begin
    next_scl_q = scl_i;
    next_sda_q = sda_i;
    next_rise  = scl_i & ~scl_q;
    next_fall  = ~scl_i & scl_q;
    // Data moving while the clock stays high frames a transfer
    next_strt  = scl_i & scl_q & sda_q & ~sda_i;
    next_stp   = scl_i & scl_q & ~sda_q & sda_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rise  <= 1'b0;
      fall  <= 1'b0;
      strt  <= 1'b0;
      stp   <= 1'b0;
    end else begin
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
      rise  <= next_rise;
      fall  <= next_fall;
      strt  <= next_strt;
      stp   <= next_stp;
    end
  end

  assign line.scl_rise = rise;
  assign line.scl_fall = fall;
  assign line.start    = strt;
  assign line.stop     = stp;
  assign line.sda      = sda_q;

endmodule : chc_line_mon
`default_nettype wire

// ### hdl/chc_regs.sv
// Word-command bus slave holding the charge current setpoint and the
// throttle trigger flags. Assumes the host drives the clock line and that
// the open-drain data line is resolved outside from the output enable.
`timescale 1ns/10ps
`default_nettype none
module chc_regs
  import chc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = chc_pkg::DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       srst_i,
  // Bus pins
  input  wire logic                       smb_scl_i,
  input  wire logic                       smb_sda_i,
  output logic                            smb_sda_o,
  output logic                            smb_sda_oe_o,
  // Charger conditions
  input  wire logic                       source_good_i,
  input  wire logic                       input_overvoltage_i,
  input  wire logic                       cell_count_presence_pin_i,
  input  wire logic [chc_pkg::FLAG_W-1:0] throttle_cond_i,
  // Results
  output logic      [chc_pkg::MA_W-1:0]   charge_current_ma_o,
  output logic      [chc_pkg::FLAG_W-1:0] throttle_flags_o
);
  import chc_pkg::*;

  chc_line_if line ();

  chc_line_mon u_chc_line_mon (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .scl_i     (smb_scl_i),
    .sda_i     (smb_sda_i),
    .line      (line.mon)
  );

  // ****************************************************************
  // Bus engine
  // ****************************************************************
  chc_state_e  state, next_state;
  logic [2:0]  bitcnt, next_bitcnt;
  logic [7:0]  shreg, next_shreg;
  logic [1:0]  idx, next_idx;
  logic        rw, next_rw;
  logic [7:0]  cmd, next_cmd;
  logic [7:0]  lo, next_lo;
  logic [15:0] rd_word, next_rd_word;
  logic        oe, next_oe;
  logic [7:0]  rx_byte;
  logic        wr_commit;
  logic        rd_start;
  logic [15:0] setpoint;
  logic [6:0]  flags;

  assign rx_byte = {shreg[6:0], line.sda};

  always_comb begin
    next_state   = state;
    next_bitcnt  = bitcnt;
    next_shreg   = shreg;
    next_idx     = idx;
    next_rw      = rw;
    next_cmd     = cmd;
    next_lo      = lo;
    next_rd_word = rd_word;
    next_oe      = oe;
    wr_commit    = 1'b0;
    rd_start     = 1'b0;
    if (line.start) begin
      next_state  = ST_RX;
      next_bitcnt = '0;
      next_idx    = IDX_ADDR;
      next_oe     = 1'b0;
    end else if (line.stop) begin
      next_state = ST_IDLE;
      next_oe    = 1'b0;
    end else begin
      case (state)
        ST_RX: begin
          if (line.scl_rise) begin
            next_shreg  = rx_byte;
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == LAST_BIT) begin
              next_state = ST_ACK_SETUP;
              case (idx)
                IDX_ADDR: begin
                  next_rw = rx_byte[0];
                  if (rx_byte[7:1] != DEV_ADDR) begin
                    next_state = ST_IGNORE;
                  end
                end
                IDX_CMD: next_cmd = rx_byte;
                IDX_LO:  next_lo  = rx_byte;
                default: begin
                  // R2 word write lands
                  wr_commit = 1'b1;
                end
              endcase
            end
          end
        end
        ST_ACK_SETUP: begin
          if (line.scl_fall) begin
            next_state = ST_ACK;
            next_oe    = 1'b1;
          end
        end
        ST_ACK: begin
          if (line.scl_fall) begin
            next_oe     = 1'b0;
            next_bitcnt = '0;
            if (rw && idx == IDX_ADDR) begin
              // R11 read word, low byte first
              rd_start     = 1'b1;
              next_rd_word = (cmd == CMD_SETPOINT) ? setpoint :
                             (cmd == CMD_THROTTLE) ? {9'h000, flags} : 16'h0000;
              next_shreg   = next_rd_word[7:0];
              next_oe      = ~next_rd_word[7];
              next_idx     = IDX_LO;
              next_state   = ST_TX;
            end else if (idx == IDX_HI) begin
              next_state = ST_IGNORE;
            end else begin
              next_idx   = idx + 2'h1;
              next_state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (line.scl_fall) begin
            if (bitcnt == LAST_BIT) begin
              next_oe    = 1'b0;
              next_state = ST_MACK;
            end else begin
              next_bitcnt = bitcnt + 3'h1;
              next_shreg  = {shreg[6:0], 1'b0};
              next_oe     = ~shreg[6];
            end
          end
        end
        ST_MACK: begin
          // A master that does not acknowledge ends the read
          if (line.scl_rise) begin
            next_state = line.sda ? ST_IGNORE : ST_MACK_HOLD;
          end
        end
        ST_MACK_HOLD: begin
          if (line.scl_fall) begin
            if (idx == IDX_LO) begin
              next_idx    = IDX_HI;
              next_bitcnt = '0;
              next_shreg  = rd_word[15:8];
              next_oe     = ~rd_word[15];
              next_state  = ST_TX;
            end else begin
              next_state = ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE: next_state = state;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state   <= ST_IDLE;
      bitcnt  <= '0;
      shreg   <= 8'h00;
      idx     <= IDX_ADDR;
      rw      <= 1'b0;
      cmd     <= 8'h00;
      lo      <= 8'h00;
      rd_word <= 16'h0000;
      oe      <= 1'b0;
    end else begin
      state   <= next_state;
      bitcnt  <= next_bitcnt;
      shreg   <= next_shreg;
      idx     <= next_idx;
      rw      <= next_rw;
      cmd     <= next_cmd;
      lo      <= next_lo;
      rd_word <= next_rd_word;
      oe      <= next_oe;
    end
  end

  // ****************************************************************
  // Setpoint and trigger flags
  // ****************************************************************
  logic        good_q, next_good_q;
  logic        pres_q, next_pres_q;
  logic [15:0] next_setpoint;
  logic [6:0]  next_flags;
  logic        src_fall, pres_fall, sp_valid;

  assign src_fall  = good_q & ~source_good_i;
  assign pres_fall = pres_q & ~cell_count_presence_pin_i;
  // R10 upper three bits must be zero
  assign sp_valid  = (rx_byte[7:INV_LSB-8] == 3'h0);

  always_comb begin
    next_good_q   = source_good_i;
    next_pres_q   = cell_count_presence_pin_i;
    next_setpoint = setpoint;
    // R8 bits 12..6 kept, R9 low bits dropped
    if (wr_commit && cmd == CMD_SETPOINT && sp_valid) begin
      next_setpoint = {3'h0, rx_byte[SP_MSB-8:0], lo[7:SP_LSB], 6'h00};
    end
    // R5 source loss clears unless overvoltage; R6 battery removal clears.
    // R7 other faults have no path here, so the setpoint survives them.
    if ((src_fall && !input_overvoltage_i) || pres_fall) begin
      next_setpoint = SETPOINT_RESET;
    end
    // R1 flags clear when read, but a new trigger wins
    next_flags = (rd_start && cmd == CMD_THROTTLE) ? FLAG_RESET : flags;
    next_flags = next_flags | throttle_cond_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      good_q   <= 1'b0;
      pres_q   <= 1'b0;
      // R4 zero at power-on
      setpoint <= SETPOINT_RESET;
      flags    <= FLAG_RESET;
    end else begin
      good_q   <= next_good_q;
      pres_q   <= next_pres_q;
      setpoint <= next_setpoint;
      flags    <= next_flags;
    end
  end

  // Open-drain: only ever pulls low
  always_ff @(posedge clk_sys_i) begin
    smb_sda_o <= 1'b0;
  end

  assign smb_sda_oe_o        = oe;
  // R3 64 mA steps
  assign charge_current_ma_o = setpoint[MA_W-1:0];
  assign throttle_flags_o    = flags;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_good_write;
    wr_commit && cmd == CMD_SETPOINT && sp_valid && !src_fall && !pres_fall;
  endsequence

  sequence s_bad_write;
    wr_commit && cmd == CMD_SETPOINT && !sp_valid && !src_fall && !pres_fall;
  endsequence

  chk_flag_sticky: assert property ( // R1
    (|throttle_cond_i) |=> ((flags & $past(throttle_cond_i)) == $past(throttle_cond_i)))
    else $error("trigger flag not set");
  chk_write_lands: assert property ( // R2
    s_good_write |=> setpoint[SP_MSB:SP_LSB] == $past({rx_byte[4:0], lo[7:6]}))
    else $error("setpoint write lost");
  chk_range_max: assert property ( // R3
    charge_current_ma_o <= MAX_MA && charge_current_ma_o[SP_LSB-1:0] == 6'h00)
    else $error("setpoint out of range");
  chk_reset_zero: assert property (@(posedge clk_sys_i) disable iff (1'b0) // R4
    srst_i |=> setpoint == SETPOINT_RESET)
    else $error("setpoint not cleared by reset");
  chk_source_clear: assert property ( // R5
    src_fall && !input_overvoltage_i |=> setpoint == SETPOINT_RESET)
    else $error("source loss did not clear setpoint");
  chk_removal_clear: assert property ( // R6
    pres_fall |=> setpoint == SETPOINT_RESET)
    else $error("battery removal did not clear setpoint");
  chk_ovp_retain: assert property ( // R5
    src_fall && input_overvoltage_i && !pres_fall && !wr_commit |=> $stable(setpoint))
    else $error("overvoltage source loss changed setpoint");
  chk_bad_write: assert property ( // R10
    s_bad_write |=> $stable(setpoint))
    else $error("invalid setpoint write accepted");
  chk_ack_pulse: assert property ( // R11
    $rose(state == ST_ACK) |-> oe ##1 (oe throughout (state == ST_ACK)[*1]))
    else $error("acknowledge not driven");
  chk_low_bits: assert property ( // R9
    setpoint[SP_LSB-1:0] == 6'h00 && setpoint[15:INV_LSB] == 3'h0)
    else $error("ignored setpoint bits stored");

endmodule : chc_regs
`default_nettype wire

// ### bench/chc_host_model.sv
// Host model for the charger bus: word write and word read.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module chc_host_model
  import chc_pkg::*;
(
  // Clock
  input  wire logic clk_sys_i,
  // Bus pins
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // 8-clock half periods keep well clear of the 4-clock minimum
  task automatic half();
    repeat (8) @(posedge clk_sys_i);
  endtask : half

  task automatic start();
    sda_oe_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_oe_o <= 1'b1;
    half();
    scl_o <= 1'b0;
    half();
  endtask : start

  task automatic stop();
    sda_oe_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_oe_o <= 1'b0;
    half();
  endtask : stop

  // Data only moves while the clock line is low, set in the same clock as its falling edge except on the first bit after a start
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o <= ~b;
    half();
    scl_o <= 1'b1;
    half();
    r = sda_i;
    scl_o <= 1'b0;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] tx, input logic a, output logic [7:0] rx,
                         output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(a, ack);
  endtask : byte_io

  task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd,
                            input logic [15:0] d, output logic [3:0] nak);
    logic [7:0] rx;
    start();
    byte_io({adr, 1'b0}, 1'b1, rx, nak[3]);
    byte_io(cmd, 1'b1, rx, nak[2]);
    byte_io(d[7:0], 1'b1, rx, nak[1]);
    byte_io(d[15:8], 1'b1, rx, nak[0]);
    stop();
  endtask : write_word

  // word read, host NACK ends it
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d,
                           output logic [2:0] nak);
    logic [7:0] rx;
    logic       a;
    start();
    byte_io({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rx, nak[2]);
    byte_io(cmd, 1'b1, rx, nak[1]);
    start();
    byte_io({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, rx, nak[0]);
    byte_io(8'hff, 1'b0, d[7:0], a);
    byte_io(8'hff, 1'b1, d[15:8], a);
    stop();
  endtask : read_word
endmodule : chc_host_model
`default_nettype wire

// ### bench/tb_charge_current_and_throttle_flags.sv
// Self-checking bench for the setpoint and throttle flag registers.
// Assumes the host model drives the clock line and a pull-up on data.
`timescale 1ns/10ps
`default_nettype none
module tb_charge_current_and_throttle_flags;
  import chc_pkg::*;
  logic              clk_sys_i;
  logic              srst_i;
  logic              scl;
  logic              host_oe;
  logic              dut_oe;
  logic              dut_sda;
  logic              sda;
  logic              good;
  logic              ovp;
  logic              pres;
  logic [FLAG_W-1:0] cond;
  logic [FLAG_W-1:0] flags;
  logic [MA_W-1:0]   ma;
  int                failures;
  int                n_compared;
  int                cycles;

  // Pull-up: the line is high unless some party pulls it low
  assign sda = ~(host_oe | (dut_oe & ~dut_sda));

  chc_host_model u_chc_host_model (
    .clk_sys_i(clk_sys_i),
    .sda_i    (sda),
    .scl_o    (scl),
    .sda_oe_o (host_oe)
  );

  chc_regs u_chc_regs (
    .clk_sys_i                (clk_sys_i),
    .srst_i                   (srst_i),
    .smb_scl_i                (scl),
    .smb_sda_i                (sda),
    .smb_sda_o                (dut_sda),
    .smb_sda_oe_o             (dut_oe),
    .source_good_i            (good),
    .input_overvoltage_i      (ovp),
    .cell_count_presence_pin_i(pres),
    .throttle_cond_i          (cond),
    .charge_current_ma_o      (ma),
    .throttle_flags_o         (flags)
  );

  always #4 clk_sys_i = ~clk_sys_i;

  // Each word transfer takes under 1000 clocks
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc

  task automatic wr(input logic [6:0] adr, input logic [15:0] d, input logic [3:0] nak_exp,
                    input logic [12:0] ma_exp);
    logic [3:0] nak;
    u_chc_host_model.write_word(adr, CMD_SETPOINT, d, nak);
    check({12'h0, nak}, {12'h0, nak_exp});
    check({3'h0, ma}, {3'h0, ma_exp});
  endtask : wr

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check({3'h0, ma}, 16'h0000);
    check({9'h0, flags}, 16'h0000);
  endtask : t_reset

  task automatic t_setpoint();
    logic [15:0] d;
    logic [2:0]  nak;
    wr(DEV_ADDR_DEFAULT, 16'h0140, 4'h0, 13'd320);
    wr(DEV_ADDR_DEFAULT, 16'h1fff, 4'h0, 13'd8128);
    wr(DEV_ADDR_DEFAULT, 16'h0040, 4'h0, 13'd64);
    wr(DEV_ADDR_DEFAULT, 16'h1000, 4'h0, 13'd4096);
    wr(DEV_ADDR_DEFAULT, 16'h2fc0, 4'h0, 13'd4096);
    wr(DEV_ADDR_DEFAULT, 16'h8040, 4'h0, 13'd4096);
    wr(DEV_ADDR_DEFAULT ^ 7'h01, 16'h0040, 4'hf, 13'd4096);
    u_chc_host_model.read_word(CMD_SETPOINT, d, nak);
    check({13'h0, nak}, 16'h0000);
    check(d, 16'h1000);
  endtask : t_setpoint

  task automatic t_events();
    ovp <= 1'b1;
    good <= 1'b0;
    cyc(4);
    check({3'h0, ma}, 16'd4096);
    good <= 1'b1;
    ovp <= 1'b0;
    cyc(4);
    good <= 1'b0;
    cyc(4);
    check({3'h0, ma}, 16'h0000);
    good <= 1'b1;
    wr(DEV_ADDR_DEFAULT, 16'h0080, 4'h0, 13'd128);
    pres <= 1'b0;
    cyc(4);
    check({3'h0, ma}, 16'h0000);
    pres <= 1'b1;
    wr(DEV_ADDR_DEFAULT, 16'h0080, 4'h0, 13'd128);
    srst_i <= 1'b1;
    cyc(2);
    srst_i <= 1'b0;
    cyc(1);
    check({3'h0, ma}, 16'h0000);
  endtask : t_events

  task automatic t_flags();
    logic [15:0] d;
    logic [2:0]  nak;
    logic [3:0]  nak4;
    logic [6:0]  pat [2] = '{7'h55, 7'h2a};
    for (int i = 0; i < 2; i++) begin
      cond <= pat[i];
      cyc(1);
      cond <= 7'h00;
      cyc(3);
      check({9'h0, flags}, {9'h0, pat[i]});
      u_chc_host_model.read_word(CMD_THROTTLE, d, nak);
      check({13'h0, nak}, 16'h0000);
      check(d, {9'h0, pat[i]});
      check({9'h0, flags}, 16'h0000);
    end
    // a standing trigger survives the read clear
    cond <= 7'h40;
    cyc(2);
    u_chc_host_model.read_word(CMD_THROTTLE, d, nak);
    check({13'h0, nak}, 16'h0000);
    check(d, 16'h0040);
    check({9'h0, flags}, 16'h0040);
    cond <= 7'h00;
    // flags are read-only, a write leaves them alone
    u_chc_host_model.write_word(DEV_ADDR_DEFAULT, CMD_THROTTLE, 16'h0000, nak4);
    check({12'h0, nak4}, 16'h0000);
    check({9'h0, flags}, 16'h0040);
    // an unmapped command code reads as zero
    u_chc_host_model.read_word(8'h15, d, nak);
    check({13'h0, nak}, 16'h0000);
    check(d, 16'h0000);
  endtask : t_flags

  initial begin
    clk_sys_i = 1'b0;
    srst_i = 1'b1;
    good = 1'b1;
    ovp = 1'b0;
    pres = 1'b1;
    cond = 7'h00;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    cyc(4);
    srst_i <= 1'b0;
    cyc(1);
    t_reset();
    t_setpoint();
    t_events();
    t_flags();
    end_of_test();
  end
endmodule : tb_charge_current_and_throttle_flags
`default_nettype wire
